// File: rtl/ifa_top.sv
`timescale 1ns/1ns
// Overview of operation
// RQ1 - One global failsafe enable, off after reset, gates all failsafe actions.
// RQ2 - After an idle interval the timer expires and outputs apply their actions.
// RQ3 - Interval is 1 to 9999 whole seconds, resetting to 30.
// RQ4 - Every output, relay and serial pin has its own activate or deactivate action.
// RQ5 - Action none leaves the output unchanged; none is the reset choice.
// RQ6 - Extension outputs use a private timer that runs while no session exists.
// RQ7 - Any qualifying activity reloads the countdown to the programmed interval.
// RQ8 - Input-mode channels sample their line; input mode is the reset setting.
// RQ9 - Per input latch of none, rising or falling transition, default none.
// RQ10 - A captured latch stays set until software acknowledges it.
// RQ11 - Inversion, off after reset, reports the complement of the line.
// RQ12 - Inactive trigger raises on active-to-inactive; disabled trigger raises nothing.
// RQ13 - Active trigger raises on inactive-to-active.
// RQ14 - Auto clear, the default, clears once the input leaves the trigger state.
// RQ15 - Manual clear keeps the alarm until an explicit clear request.
// RQ16 - Each raise and clear emits an event, gated by notification paths off at reset.
// RQ17 - A disabled channel does no sampling, alarm or output activity.
module ifa_top
#(
   parameter int NIN = 4,
   parameter int NDOUT = 4,
   parameter int NRELAY = 2,
   parameter int NSERIAL = 2,
   parameter int TICK_CYCLES = ifa_pkg::CYCLES_PER_SEC
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [NIN-1:0] dinLine,
   input wire logic [NDOUT+NRELAY+NSERIAL-1:0] sessionActive,
   output logic [NDOUT+NRELAY+NSERIAL-1:0] outDrive,
   output logic failsafeExpired,
   output logic [NIN-1:0] notifyRaise,
   output logic [NIN-1:0] notifyClear,
   output logic [2:0] notifyPath
);
   localparam int NOUT = NDOUT + NRELAY + NSERIAL;
   localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

   logic [31:0] prdata_reg, rdMux;
   logic pready_reg, pslverr_reg, addrHit, access, done, wrEn;
   logic [3:0] ctrl_reg;
   logic [13:0] timeout_reg, timeoutNext, fsCount_reg;
   logic [NIN-1:0] inEn_reg;
   logic [NOUT-1:0] outEn_reg, outState_reg, outExt_reg, extExp_reg, fire, extFire;
   logic [NIN*ifa_pkg::CFG_W-1:0] dinCfg_reg;
   logic [2*NOUT-1:0] fsAct_reg;
   logic [13:0] extCount_reg [NOUT];
   logic [31:0] preCnt_reg;
   logic expired_reg, tick, fsEn, act, globalFire, anyPath;
   logic [NIN-1:0] notifyRaise_reg, notifyClear_reg;
   logic [2:0] notifyPath_reg;
   logic [31:0] ctrlRd, chenRd, cfgRd, outRd, fsRd, statRd;
   logic [31:0] ctrlWr, toWr, chenWr, cfgWr, outWr, fsWr;
   logic wrCtrl, wrTimeout, wrChen, wrCfg, wrOut, wrFs, wrAck;
   logic [NIN-1:0] inStatus, inLatched, inAlarm, inChange, inRaise, inClear, ackLatch, clrAlarm;

   function automatic logic [31:0] applyStrb
   (
      input logic [31:0] old,
      input logic [31:0] data,
      input logic [3:0] strb
   );
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++)
         if (strb[b])
            res[8*b +: 8] = data[8*b +: 8];
      return res;
   endfunction : applyStrb

   // APB slave, one wait state
   assign access = psel && penable;
   assign done = access && pready_reg;
   assign wrEn = done && pwrite;
   assign wrCtrl = wrEn && paddr == ifa_pkg::ADDR_CTRL;
   assign wrTimeout = wrEn && paddr == ifa_pkg::ADDR_TIMEOUT;
   assign wrChen = wrEn && paddr == ifa_pkg::ADDR_CHEN;
   assign wrCfg = wrEn && paddr == ifa_pkg::ADDR_DINCFG;
   assign wrOut = wrEn && paddr == ifa_pkg::ADDR_OUT;
   assign wrFs = wrEn && paddr == ifa_pkg::ADDR_FSACT;
   assign wrAck = wrEn && paddr == ifa_pkg::ADDR_ACK;

   assign ctrlRd = 32'(ctrl_reg);
   assign chenRd = 32'(inEn_reg) | (32'(outEn_reg) << ifa_pkg::CHEN_OUT_LSB);
   assign cfgRd = 32'(dinCfg_reg);
   assign outRd = 32'(outState_reg) | (32'(outExt_reg) << ifa_pkg::OUT_EXT_LSB);
   assign fsRd = 32'(fsAct_reg);
   assign statRd = 32'(inStatus) | (32'(inLatched) << ifa_pkg::STAT_LATCH_LSB)
      | (32'(inAlarm) << ifa_pkg::STAT_ALARM_LSB) | (32'(expired_reg) << ifa_pkg::STAT_EXP_BIT);
   assign ctrlWr = applyStrb(ctrlRd, pwdata, pstrb);
   assign toWr = applyStrb(32'(timeout_reg), pwdata, pstrb);
   assign chenWr = applyStrb(chenRd, pwdata, pstrb);
   assign cfgWr = applyStrb(cfgRd, pwdata, pstrb);
   assign outWr = applyStrb(outRd, pwdata, pstrb);
   assign fsWr = applyStrb(fsRd, pwdata, pstrb);
   assign ackLatch = wrAck ? pwdata[NIN-1:0] : '0;
   assign clrAlarm = wrAck ? pwdata[ifa_pkg::ACK_CLR_LSB +: NIN] : '0;

   always_comb
   begin
      rdMux = 32'h00000000;
      addrHit = 1'b1;
      case (paddr)
         ifa_pkg::ADDR_CTRL: rdMux = ctrlRd;
         ifa_pkg::ADDR_TIMEOUT: rdMux = 32'(timeout_reg);
         ifa_pkg::ADDR_CHEN: rdMux = chenRd;
         ifa_pkg::ADDR_DINCFG: rdMux = cfgRd;
         ifa_pkg::ADDR_OUT: rdMux = outRd;
         ifa_pkg::ADDR_FSACT: rdMux = fsRd;
         ifa_pkg::ADDR_STATUS: rdMux = statRd;
         ifa_pkg::ADDR_COUNT: rdMux = 32'(fsCount_reg);
         ifa_pkg::ADDR_ACK: rdMux = 32'h00000000;
         default: addrHit = 1'b0;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         pready_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         pready_reg <= access && !pready_reg;
         if (access && !pready_reg)
         begin
            prdata_reg <= pwrite ? 32'h00000000 : rdMux;
            pslverr_reg <= !addrHit;
         end
         else
            pslverr_reg <= 1'b0;
      end
   end

   // RQ3 clamp interval to its legal range
   always_comb
   begin
      timeoutNext = toWr[13:0];
      if (toWr[31:14] != 18'h00000 || toWr[13:0] > ifa_pkg::TIMEOUT_MAX)
         timeoutNext = ifa_pkg::TIMEOUT_MAX;
      else if (toWr[13:0] < ifa_pkg::TIMEOUT_MIN)
         timeoutNext = ifa_pkg::TIMEOUT_MIN;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ctrl_reg <= ifa_pkg::CTRL_RST[3:0];
         timeout_reg <= ifa_pkg::TIMEOUT_RST;
         inEn_reg <= ifa_pkg::CHEN_RST[NIN-1:0];
         outEn_reg <= ifa_pkg::CHEN_RST[ifa_pkg::CHEN_OUT_LSB +: NOUT];
         dinCfg_reg <= ifa_pkg::DINCFG_RST[NIN*ifa_pkg::CFG_W-1:0];
         outExt_reg <= ifa_pkg::OUT_RST[ifa_pkg::OUT_EXT_LSB +: NOUT];
         fsAct_reg <= ifa_pkg::FSACT_RST[2*NOUT-1:0];
      end
      else
      begin
         if (wrCtrl)
            ctrl_reg <= ctrlWr[3:0];
         if (wrTimeout)
            timeout_reg <= timeoutNext;
         if (wrChen)
         begin
            inEn_reg <= chenWr[NIN-1:0];
            outEn_reg <= chenWr[ifa_pkg::CHEN_OUT_LSB +: NOUT];
         end
         if (wrCfg)
            dinCfg_reg <= cfgWr[NIN*ifa_pkg::CFG_W-1:0];
         if (wrOut)
            outExt_reg <= outWr[ifa_pkg::OUT_EXT_LSB +: NOUT];
         if (wrFs)
            fsAct_reg <= fsWr[2*NOUT-1:0];
      end
   end

   // RQ1 global failsafe enable
   assign fsEn = ctrl_reg[ifa_pkg::CTRL_FS_EN];
   // RQ7 activity sources that restart the idle interval
   assign act = wrOut || wrTimeout || wrFs || (|inChange);
   assign tick = fsEn && preCnt_reg == TICK_LAST;

   always_ff @(posedge clk)
   begin
      if (srst || !fsEn || tick)
         preCnt_reg <= 32'h00000000;
      else
         preCnt_reg <= preCnt_reg + 32'h00000001;
   end

   // RQ2 RQ7 global idle countdown
   assign globalFire = fsEn && !act && tick && !expired_reg && fsCount_reg == 14'h0000;
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         fsCount_reg <= ifa_pkg::TIMEOUT_RST;
         expired_reg <= 1'b0;
      end
      else if (!fsEn || act)
      begin
         fsCount_reg <= wrTimeout ? timeoutNext : timeout_reg;
         expired_reg <= 1'b0;
      end
      else if (tick && !expired_reg)
      begin
         if (fsCount_reg == 14'h0000)
            expired_reg <= 1'b1;
         else
            fsCount_reg <= fsCount_reg - 14'h0001;
      end
   end

   // RQ6 per output session timers
   always_ff @(posedge clk)
   begin
      for (int i = 0; i < NOUT; i++)
      begin
         if (srst)
         begin
            extCount_reg[i] <= ifa_pkg::TIMEOUT_RST;
            extExp_reg[i] <= 1'b0;
         end
         else if (!fsEn || !outExt_reg[i] || sessionActive[i])
         begin
            extCount_reg[i] <= timeout_reg;
            extExp_reg[i] <= 1'b0;
         end
         else if (tick && !extExp_reg[i])
         begin
            if (extCount_reg[i] == 14'h0000)
               extExp_reg[i] <= 1'b1;
            else
               extCount_reg[i] <= extCount_reg[i] - 14'h0001;
         end
      end
   end

   always_comb
   begin
      for (int i = 0; i < NOUT; i++)
      begin
         extFire[i] = fsEn && outExt_reg[i] && !sessionActive[i] && tick && !extExp_reg[i]
            && extCount_reg[i] == 14'h0000;
         fire[i] = outExt_reg[i] ? extFire[i] : globalFire;
      end
   end

   // RQ4 RQ5 RQ17 output state with failsafe actions
   always_ff @(posedge clk)
   begin
      for (int i = 0; i < NOUT; i++)
      begin
         if (srst)
            outState_reg[i] <= ifa_pkg::OUT_RST[i];
         else if (!outEn_reg[i])
            outState_reg[i] <= 1'b0;
         else if (wrOut)
            outState_reg[i] <= outWr[i];
         else if (fire[i] && fsAct_reg[2*i +: 2] == ifa_pkg::FS_ACTIVATE)
            outState_reg[i] <= 1'b1;
         else if (fire[i] && fsAct_reg[2*i +: 2] == ifa_pkg::FS_DEACTIVATE)
            outState_reg[i] <= 1'b0;
      end
   end

   for (genvar g = 0; g < NIN; g++)
   begin : gIn
      ifa_chan_if chIf ();
      assign chIf.en = inEn_reg[g];
      assign chIf.cfg = dinCfg_reg[g*ifa_pkg::CFG_W +: ifa_pkg::CFG_W];
      assign chIf.ackLatch = ackLatch[g];
      assign chIf.clrAlarm = clrAlarm[g];
      assign inStatus[g] = chIf.status;
      assign inLatched[g] = chIf.latched;
      assign inAlarm[g] = chIf.alarm;
      assign inChange[g] = chIf.change;
      assign inRaise[g] = chIf.raiseEvt;
      assign inClear[g] = chIf.clearEvt;
      ifa_din_chan uChan
      (
         .clk(clk),
         .srst(srst),
         .line(dinLine[g]),
         .ch(chIf)
      );
   end

   // RQ16 gated notification events
   assign anyPath = |ctrl_reg[ifa_pkg::CTRL_PATH_LSB +: ifa_pkg::PATH_W];
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         notifyRaise_reg <= '0;
         notifyClear_reg <= '0;
         notifyPath_reg <= 3'h0;
      end
      else
      begin
         notifyRaise_reg <= anyPath ? inRaise : '0;
         notifyClear_reg <= anyPath ? inClear : '0;
         notifyPath_reg <= (|{inRaise, inClear}) ? ctrl_reg[ifa_pkg::CTRL_PATH_LSB +: 3] : 3'h0;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign outDrive = outState_reg;
   assign failsafeExpired = expired_reg;
   assign notifyRaise = notifyRaise_reg;
   assign notifyClear = notifyClear_reg;
   assign notifyPath = notifyPath_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence seqCountDone;
      fsEn && !act && tick && !expired_reg && fsCount_reg == 14'h0000;
   endsequence
   sequence seqActivity;
      fsEn && act;
   endsequence

   AST_TIMEOUT_RANGE: assert property (timeout_reg >= ifa_pkg::TIMEOUT_MIN
      && timeout_reg <= ifa_pkg::TIMEOUT_MAX) // RQ3
      else $error("interval out of range");
   AST_FS_DISABLED: assert property (!fsEn |=> !expired_reg && extExp_reg == '0) // RQ1
      else $error("expiry while failsafe disabled");
   AST_EXPIRE: assert property (seqCountDone |=> expired_reg
      ##1 (expired_reg || $past(act) || !$past(fsEn))) // RQ2
      else $error("countdown end did not expire");
   AST_RELOAD: assert property (seqActivity |=> fsCount_reg == timeout_reg && !expired_reg) // RQ7
      else $error("activity did not reload countdown");
   AST_NOTIFY: assert property (anyPath && (|inRaise) |=> notifyRaise_reg == $past(inRaise)) // RQ16
      else $error("raise event lost");
   AST_NOTIFY_OFF: assert property (!anyPath |=> notifyRaise_reg == '0 && notifyClear_reg == '0) // RQ16
      else $error("event with all paths off");

   for (genvar k = 0; k < NOUT; k++)
   begin : gAst
      AST_ACT_ON: assert property (outEn_reg[k] && !wrOut && fire[k]
         && fsAct_reg[2*k +: 2] == ifa_pkg::FS_ACTIVATE |=> outState_reg[k]) // RQ4
         else $error("activate action not applied");
      AST_NONE_HOLD: assert property (outEn_reg[k] && !wrOut && fire[k]
         && fsAct_reg[2*k +: 2] == ifa_pkg::FS_NONE |=> $stable(outState_reg[k])) // RQ5
         else $error("none action changed output");
      AST_EXT_SESSION: assert property (outEn_reg[k] && outExt_reg[k] && sessionActive[k]
         && !wrOut |=> $stable(outState_reg[k])) // RQ6
         else $error("extension output fired during session");
      AST_OUT_DISABLED: assert property (!outEn_reg[k] |=> !outState_reg[k]) // RQ17
         else $error("disabled output driven");
   end
endmodule : ifa_top

// File: include/ifa_pkg.sv
package ifa_pkg;
   // Timing base for the seconds prescaler
   localparam int CLK_PERIOD_NS = 4;
   localparam int SECOND_NS = 1000000000;
   localparam int CYCLES_PER_SEC = SECOND_NS / CLK_PERIOD_NS;

   // Failsafe interval in whole seconds
   localparam int SEC_W = 14;
   localparam logic [13:0] TIMEOUT_MIN = 14'h0001;
   localparam logic [13:0] TIMEOUT_MAX = 14'h270f;
   localparam logic [13:0] TIMEOUT_RST = 14'h001e;

   // Register byte offsets
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_TIMEOUT = 12'h004;
   localparam logic [11:0] ADDR_CHEN = 12'h008;
   localparam logic [11:0] ADDR_DINCFG = 12'h00c;
   localparam logic [11:0] ADDR_OUT = 12'h010;
   localparam logic [11:0] ADDR_FSACT = 12'h014;
   localparam logic [11:0] ADDR_STATUS = 12'h018;
   localparam logic [11:0] ADDR_COUNT = 12'h01c;
   localparam logic [11:0] ADDR_ACK = 12'h020;

   // Field positions
   localparam int CTRL_FS_EN = 0;
   localparam int CTRL_PATH_LSB = 1;
   localparam int PATH_W = 3;
   localparam int CHEN_OUT_LSB = 16;
   localparam int OUT_EXT_LSB = 16;
   localparam int ACK_CLR_LSB = 16;
   localparam int STAT_LATCH_LSB = 8;
   localparam int STAT_ALARM_LSB = 16;
   localparam int STAT_EXP_BIT = 24;
   localparam int CFG_W = 8;
   localparam int CFG_LATCH_LSB = 0;
   localparam int CFG_INV = 2;
   localparam int CFG_TRIG_LSB = 3;
   localparam int CFG_MANCLR = 5;
   localparam int CFG_OUTMODE = 6;

   // Reset values
   localparam logic [31:0] CTRL_RST = 32'h00000000;
   localparam logic [31:0] CHEN_RST = 32'h00000000;
   localparam logic [31:0] DINCFG_RST = 32'h00000000;
   localparam logic [31:0] OUT_RST = 32'h00000000;
   localparam logic [31:0] FSACT_RST = 32'h00000000;

   typedef enum logic [1:0] {LATCH_NONE = 2'h0, LATCH_RISE = 2'h1, LATCH_FALL = 2'h2} ifa_latch_t;
   typedef enum logic [1:0] {TRIG_OFF = 2'h0, TRIG_INACTIVE = 2'h1, TRIG_ACTIVE = 2'h2} ifa_trig_t;
   typedef enum logic [1:0] {FS_NONE = 2'h0, FS_ACTIVATE = 2'h1, FS_DEACTIVATE = 2'h2} ifa_fsact_t;
endpackage : ifa_pkg

// File: include/ifa_chan_if.sv
`timescale 1ns/1ns
interface ifa_chan_if;
   logic en;
   logic [7:0] cfg;
   logic ackLatch;
   logic clrAlarm;
   logic status;
   logic latched;
   logic alarm;
   logic change;
   logic raiseEvt;
   logic clearEvt;
   modport ctl
   (
      output en, cfg, ackLatch, clrAlarm,
      input status, latched, alarm, change, raiseEvt, clearEvt
   );
   modport chan
   (
      input en, cfg, ackLatch, clrAlarm,
      output status, latched, alarm, change, raiseEvt, clearEvt
   );
endinterface : ifa_chan_if

// File: rtl/ifa_din_chan.sv
`timescale 1ns/1ns
module ifa_din_chan
(
   input wire logic clk,
   input wire logic srst,
   input wire logic line,
   ifa_chan_if.chan ch
);
   logic syncA_reg, syncB_reg, status_reg, latched_reg, alarm_reg, raise_reg, clear_reg;
   logic sampled, cur, rise, fall, manual, raiseCond, clearCond;
   ifa_pkg::ifa_latch_t latchSel;
   ifa_pkg::ifa_trig_t trig;

   assign latchSel = ifa_pkg::ifa_latch_t'(ch.cfg[ifa_pkg::CFG_LATCH_LSB +: 2]);
   assign trig = ifa_pkg::ifa_trig_t'(ch.cfg[ifa_pkg::CFG_TRIG_LSB +: 2]);
   assign manual = ch.cfg[ifa_pkg::CFG_MANCLR];
   // RQ8 RQ17 sample enabled inputs
   assign sampled = ch.en && !ch.cfg[ifa_pkg::CFG_OUTMODE];
   // RQ11 optional inversion
   assign cur = syncB_reg ^ ch.cfg[ifa_pkg::CFG_INV];
   assign rise = sampled && cur && !status_reg;
   assign fall = sampled && !cur && status_reg;

   always_comb
   begin
      raiseCond = 1'b0;
      clearCond = 1'b1;
      case (trig)
         // RQ13 RQ14 RQ15 active trigger
         ifa_pkg::TRIG_ACTIVE:
         begin
            raiseCond = rise;
            clearCond = manual ? ch.clrAlarm : fall;
         end
         // RQ12 inactive trigger
         ifa_pkg::TRIG_INACTIVE:
         begin
            raiseCond = fall;
            clearCond = manual ? ch.clrAlarm : rise;
         end
         default:
         begin
            raiseCond = 1'b0;
            clearCond = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      syncA_reg <= line;
      syncB_reg <= syncA_reg;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         status_reg <= 1'b0;
      else
         status_reg <= sampled ? cur : 1'b0;
   end

   // RQ9 RQ10 transition latch, capture wins
   always_ff @(posedge clk)
   begin
      if (srst)
         latched_reg <= 1'b0;
      else if ((latchSel == ifa_pkg::LATCH_RISE && rise) || (latchSel == ifa_pkg::LATCH_FALL && fall))
         latched_reg <= 1'b1;
      else if (ch.ackLatch)
         latched_reg <= 1'b0;
   end

   // RQ16 alarm state and raise or clear events
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         alarm_reg <= 1'b0;
         raise_reg <= 1'b0;
         clear_reg <= 1'b0;
      end
      else
      begin
         raise_reg <= ch.en && !alarm_reg && raiseCond;
         clear_reg <= ch.en && alarm_reg && !raiseCond && clearCond;
         if (ch.en && raiseCond)
            alarm_reg <= 1'b1;
         else if (ch.en && clearCond)
            alarm_reg <= 1'b0;
      end
   end

   assign ch.status = status_reg;
   assign ch.latched = latched_reg;
   assign ch.alarm = alarm_reg;
   assign ch.change = rise || fall;
   assign ch.raiseEvt = raise_reg;
   assign ch.clearEvt = clear_reg;

   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   AST_SAMPLE_OFF: assert property (!sampled |=> !status_reg) // RQ8
      else $error("status moved while not sampling");
   AST_INVERT: assert property (sampled |=> status_reg == $past(cur)) // RQ11
      else $error("reported status not line xor invert");
   AST_LATCH_HOLD: assert property (latched_reg && !ch.ackLatch |=> latched_reg) // RQ10
      else $error("latch dropped without acknowledge");
   AST_RAISE_INACT: assert property (trig == ifa_pkg::TRIG_INACTIVE && fall && !alarm_reg
      |=> alarm_reg && raise_reg) // RQ12
      else $error("inactive trigger did not raise");
   AST_RAISE_ACT: assert property (trig == ifa_pkg::TRIG_ACTIVE && rise && !alarm_reg
      |=> alarm_reg && raise_reg) // RQ13
      else $error("active trigger did not raise");
   AST_AUTO_CLR: assert property (trig == ifa_pkg::TRIG_ACTIVE && !manual && alarm_reg && fall
      |=> !alarm_reg && clear_reg) // RQ14
      else $error("auto clear failed");
   AST_MAN_HOLD: assert property ((trig == ifa_pkg::TRIG_ACTIVE || trig == ifa_pkg::TRIG_INACTIVE)
      && manual && alarm_reg && !ch.clrAlarm
      |=> alarm_reg) // RQ15
      else $error("manual alarm cleared without request");
endmodule : ifa_din_chan

// File: test/ifa_field_model.sv
`timescale 1ns/1ns
module ifa_field_model
(
   input wire logic clk,
   input wire logic [3:0] sensorOn,
   input wire logic [7:0] linkUp,
   output logic [3:0] dinLine,
   output logic [7:0] sessionActive
);
   // Contacts and sessions settle one cycle after a change
   always_ff @(posedge clk)
   begin
      dinLine <= sensorOn;
      sessionActive <= linkUp;
   end
endmodule : ifa_field_model

// File: test/io_failsafe_and_input_alarm_tb_top.sv
`timescale 1ns/1ns
module io_failsafe_and_input_alarm_tb_top;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [3:0] sensorOn = 4'h0;
   logic [7:0] linkUp = 8'h00;
   logic [3:0] dinLine;
   logic [7:0] sessionActive;
   logic [7:0] outDrive;
   logic failsafeExpired;
   logic [3:0] notifyRaise;
   logic [3:0] notifyClear;
   logic [2:0] notifyPath;
   int errors = 0;
   int n_checks = 0;

   ifa_top #(.TICK_CYCLES(10)) u_ifa_top
   (
      .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .dinLine(dinLine),
      .sessionActive(sessionActive), .outDrive(outDrive),
      .failsafeExpired(failsafeExpired), .notifyRaise(notifyRaise),
      .notifyClear(notifyClear), .notifyPath(notifyPath)
   );
   ifa_field_model u_ifa_field_model
   (
      .clk(clk), .sensorOn(sensorOn), .linkUp(linkUp),
      .dinLine(dinLine), .sessionActive(sessionActive)
   );

   initial
   begin
      forever #2 clk = ~clk;
   end

   task final_report;
      if (errors == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : final_report

   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
      int i;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (i = 0; i < 50; i++)
      begin
         @(posedge clk);
         if (pready === 1'b1)
            break;
      end
      if (i == 50)
      begin
         errors++;
         final_report();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task rd(input string nm, input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk(nm, exp, r);
   endtask : rd

   // Waits for expiry (0), raise (1) or clear (2) of input 0
   task wt(input int k, input string nm);
      int i;
      logic hit;
      hit = 1'b0;
      for (i = 0; i < 300 && !hit; i++)
      begin
         @(posedge clk);
         hit = k == 0 ? failsafeExpired === 1'b1 :
               k == 1 ? notifyRaise[0] === 1'b1 : notifyClear[0] === 1'b1;
      end
      if (!hit)
      begin
         errors++;
         $display("[FAIL] %s expected 1 seen 0", nm);
         final_report();
      end
   endtask : wt

   task t_reset;
      logic [31:0] r;
      logic e;
      rd("ctrl", ifa_pkg::ADDR_CTRL, 32'h0);
      rd("timeout", ifa_pkg::ADDR_TIMEOUT, 32'h1e);
      rd("dincfg", ifa_pkg::ADDR_DINCFG, 32'h0);
      rd("fsact", ifa_pkg::ADDR_FSACT, 32'h0);
      rd("chen", ifa_pkg::ADDR_CHEN, 32'h0);
      apb(1'b0, 12'h024, 32'h0, r, e);
      chk("unmapped", 32'h1, {31'h0, e});
      wr(ifa_pkg::ADDR_TIMEOUT, 32'h0);
      rd("tmin", ifa_pkg::ADDR_TIMEOUT, 32'h1);
      wr(ifa_pkg::ADDR_TIMEOUT, 32'h3fff);
      rd("tmax", ifa_pkg::ADDR_TIMEOUT, 32'h270f);
   endtask : t_reset

   task t_failsafe;
      wr(ifa_pkg::ADDR_CHEN, 32'h00ff0000);
      wr(ifa_pkg::ADDR_FSACT, 32'h9);
      wr(ifa_pkg::ADDR_OUT, 32'h2);
      wr(ifa_pkg::ADDR_TIMEOUT, 32'h1);
      rd("count", ifa_pkg::ADDR_COUNT, 32'h1);
      repeat (60) @(posedge clk);
      chk("noexp", 32'h0, {31'h0, failsafeExpired});
      chk("manout", 32'h2, {24'h0, outDrive});
      wr(ifa_pkg::ADDR_CTRL, 32'h1);
      wt(0, "expired");
      repeat (2) @(posedge clk);
      chk("fsout", 32'h1, {24'h0, outDrive});
      wr(ifa_pkg::ADDR_OUT, 32'h2);
      repeat (5) @(posedge clk);
      chk("reload", 32'h0, {31'h0, failsafeExpired});
      chk("reout", 32'h2, {24'h0, outDrive});
      wr(ifa_pkg::ADDR_CTRL, 32'h0);
   endtask : t_failsafe

   task t_ext;
      wr(ifa_pkg::ADDR_FSACT, 32'h10);
      wr(ifa_pkg::ADDR_OUT, 32'h00040000);
      linkUp <= 8'h04;
      wr(ifa_pkg::ADDR_CTRL, 32'h1);
      repeat (60) @(posedge clk);
      chk("session", 32'h0, {24'h0, outDrive});
      linkUp <= 8'h00;
      repeat (40) @(posedge clk);
      chk("extout", 32'h4, {24'h0, outDrive});
      wr(ifa_pkg::ADDR_CTRL, 32'h0);
   endtask : t_ext

   task t_alarm;
      wr(ifa_pkg::ADDR_CTRL, 32'h2);
      wr(ifa_pkg::ADDR_CHEN, 32'h1);
      wr(ifa_pkg::ADDR_DINCFG, 32'h11);
      sensorOn <= 4'h1;
      wt(1, "raise");
      chk("path", 32'h1, {29'h0, notifyPath});
      rd("stat", ifa_pkg::ADDR_STATUS, 32'h00010101);
      sensorOn <= 4'h0;
      wt(2, "clear");
      rd("latch", ifa_pkg::ADDR_STATUS, 32'h100);
      wr(ifa_pkg::ADDR_ACK, 32'h1);
      rd("ack", ifa_pkg::ADDR_STATUS, 32'h0);
   endtask : t_alarm

   task t_manual;
      wr(ifa_pkg::ADDR_DINCFG, 32'h2c);
      repeat (10) @(posedge clk);
      sensorOn <= 4'h1;
      wt(1, "raiseinv");
      sensorOn <= 4'h0;
      repeat (20) @(posedge clk);
      rd("held", ifa_pkg::ADDR_STATUS, 32'h10001);
      wr(ifa_pkg::ADDR_ACK, 32'h10000);
      wt(2, "manclr");
      rd("afterclr", ifa_pkg::ADDR_STATUS, 32'h1);
      wr(ifa_pkg::ADDR_CHEN, 32'h0);
      sensorOn <= 4'h1;
      repeat (20) @(posedge clk);
      rd("disabled", ifa_pkg::ADDR_STATUS, 32'h0);
   endtask : t_manual

   initial
   begin
      repeat (20) @(posedge clk);
      srst <= 1'b0;
      t_reset();
      t_failsafe();
      t_ext();
      t_alarm();
      t_manual();
      final_report();
   end
endmodule : io_failsafe_and_input_alarm_tb_top
